// [rhf_rx_filter.sv]
// Receive header filter with best-effort and media client ports
//
// The placing of the registers and the Avalon-MM register port were decided locally.

module rhf_rx_filter
    import rhf_pkg::*;
(
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic rx_clk_en,
    // Register bus
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [WORD_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [WORD_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // MAC client receive stream
    input wire logic [BYTE_W-1:0] mac_rx_data,
    input wire logic mac_rx_data_valid,
    input wire logic mac_rx_good_frame,
    input wire logic mac_rx_bad_frame,
    // Best-effort client port
    output logic [BYTE_W-1:0] be_rx_data,
    output logic be_rx_data_valid,
    output logic be_rx_end_ok,
    output logic be_rx_end_error,
    output logic [NUM_FILT-1:0] be_rx_filter_match,
    // Media client port
    output logic [BYTE_W-1:0] media_rx_data,
    output logic media_rx_data_valid,
    output logic media_rx_end_ok,
    output logic media_rx_end_error,
    output logic [NUM_FILT-1:0] media_rx_filter_match
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic promisc_r;
    logic [7:0] prio_r;
    logic [NUM_FILT-1:0][HDR_BITS-1:0] pat_r;
    logic [NUM_FILT-1:0][HDR_BITS-1:0] msk_r;
    logic [HDR_BITS-1:0] hdr_r;
    logic [4:0] byte_cnt_r;
    logic in_frame_r;
    logic tail_prev_r;
    logic frame_acc_r;
    logic frame_av_r;
    logic frame_prom_r;
    logic frame_bcast_r;
    logic [NUM_FILT-1:0] frame_match_r;
    logic [15:0] good_cnt_r;
    logic bus_req;
    logic bus_wr;
    logic [1:0] region;
    logic [4:0] word_idx;
    logic [WORD_W-1:0] rd_word;
    logic [NUM_FILT-1:0] filt_hit;
    logic is_bcast;
    logic is_vlan;
    logic [PRIO_W-1:0] vlan_prio;
    logic av_hit;
    logic accept;
    logic [NUM_FILT-1:0] match_vec;
    logic [DLY_W-1:0] tail;
    logic tail_valid;
    logic tail_good;
    logic tail_bad;
    logic [BYTE_W-1:0] tail_data;
    logic sof;
    logic frame_acc_nxt;
    logic frame_av_nxt;
    logic [NUM_FILT-1:0] frame_match_nxt;

    // ************************************************************
    // Register bus slave
    // ************************************************************
    assign bus_req = avs_read | avs_write;
    assign bus_wr = avs_write & ~avs_waitrequest;
    assign region = avs_address[ADDR_W-1:ADDR_W-2];
    assign word_idx = avs_address[4:0];

    // One wait cycle, then a single low cycle; back-to-back allowed
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
        end else if (rx_clk_en) begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
        end
    end

    always_comb begin
        rd_word = WORD_ZERO;
        unique case (region)
            REGION_CTL: begin
                if (word_idx == REG_CTRL) begin
                    rd_word[CTRL_PROMISC] = promisc_r;
                end else if (word_idx == REG_PRIO) begin
                    rd_word[7:0] = prio_r;
                end else if (word_idx == REG_STAT) begin
                    rd_word[NUM_FILT-1:0] = frame_match_r;
                    rd_word[STAT_AV] = frame_av_r;
                    rd_word[STAT_CNT_LSB +: 16] = good_cnt_r;
                end
            end
            REGION_PAT: rd_word = pat_r[word_idx[4:2]][word_idx[1:0]*WORD_W +: WORD_W];
            REGION_MSK: rd_word = msk_r[word_idx[4:2]][word_idx[1:0]*WORD_W +: WORD_W];
            default: rd_word = WORD_ZERO;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            avs_readdata <= WORD_ZERO;
        end else if (rx_clk_en && avs_read && avs_waitrequest) begin
            avs_readdata <= rd_word;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            promisc_r <= PROMISC_RST;
            prio_r <= PRIO_RST;
        end else if (rx_clk_en && bus_wr && region == REGION_CTL) begin
            if (word_idx == REG_CTRL && avs_byteenable[0]) begin
                promisc_r <= avs_writedata[CTRL_PROMISC];
            end
            if (word_idx == REG_PRIO && avs_byteenable[0]) begin
                prio_r <= avs_writedata[7:0];
            end
        end
    end

    // Pattern and mask words, word 0 holds the first received bits
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pat_r <= '0;
            msk_r <= '0;
        end else if (rx_clk_en && bus_wr) begin
            if (region == REGION_PAT) begin
                pat_r[word_idx[4:2]][word_idx[1:0]*WORD_W +: WORD_W] <= be_merge(
                    pat_r[word_idx[4:2]][word_idx[1:0]*WORD_W +: WORD_W],
                    avs_writedata, avs_byteenable);
            end
            if (region == REGION_MSK) begin
                msk_r[word_idx[4:2]][word_idx[1:0]*WORD_W +: WORD_W] <= be_merge(
                    msk_r[word_idx[4:2]][word_idx[1:0]*WORD_W +: WORD_W],
                    avs_writedata, avs_byteenable);
            end
        end
    end

    // ************************************************************
    // Header capture
    // ************************************************************
    // Bytes land little end first so header bit 0 is the first bit
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hdr_r <= '0;
            byte_cnt_r <= '0;
            in_frame_r <= 1'b0;
        end else if (rx_clk_en) begin
            if (mac_rx_data_valid && !in_frame_r) begin
                hdr_r <= {{(HDR_BITS-BYTE_W){1'b0}}, mac_rx_data};
                byte_cnt_r <= 5'h01;
                in_frame_r <= 1'b1;
            end else if (mac_rx_data_valid && byte_cnt_r < HDR_CNT_FULL) begin
                hdr_r[byte_cnt_r*BYTE_W +: BYTE_W] <= mac_rx_data;
                byte_cnt_r <= byte_cnt_r + 5'h01;
            end
            if (mac_rx_good_frame || mac_rx_bad_frame) begin
                in_frame_r <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Filtering and routing decision
    // ************************************************************
    rhf_filter_bank u_filters (
        .hdr(hdr_r),
        .pattern(pat_r),
        .enable_mask(msk_r),
        .hit(filt_hit)
    );

    assign is_bcast = &hdr_r[DA_BITS-1:0];
    assign is_vlan = hdr_byte(hdr_r, TPID_HI_BYTE) == TPID_HI
        && hdr_byte(hdr_r, TPID_LO_BYTE) == TPID_LO;
    assign vlan_prio = hdr_r[TCI_BYTE*BYTE_W + PRIO_LSB +: PRIO_W];
    assign av_hit = is_vlan
        && ((prio_r[PRIO_A_EN] && vlan_prio == prio_r[PRIO_A_LSB +: PRIO_W])
        || (prio_r[PRIO_B_EN] && vlan_prio == prio_r[PRIO_B_LSB +: PRIO_W]));
    assign accept = promisc_r | is_bcast | (|filt_hit);
    assign match_vec = (promisc_r | is_bcast) ? '1 : filt_hit;

    // ************************************************************
    // Delayed stream and per-frame latch
    // ************************************************************
    // Sixteen bytes of delay let the header be seen before byte 0 leaves
    rhf_delay u_delay (
        .sys_clk(sys_clk),
        .reset(reset),
        .rx_clk_en(rx_clk_en),
        .din({mac_rx_bad_frame, mac_rx_good_frame, mac_rx_data_valid, mac_rx_data}),
        .dout(tail)
    );

    assign tail_data = tail[BYTE_W-1:0];
    assign tail_valid = tail[BYTE_W];
    assign tail_good = tail[BYTE_W+1];
    assign tail_bad = tail[BYTE_W+2];
    assign sof = tail_valid & ~tail_prev_r;
    assign frame_acc_nxt = sof ? accept : frame_acc_r;
    assign frame_av_nxt = sof ? av_hit : frame_av_r;
    assign frame_match_nxt = sof ? match_vec : frame_match_r;

    // Decision held for the whole frame; runts under 16 bytes use a partial header
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tail_prev_r <= 1'b0;
            frame_acc_r <= 1'b0;
            frame_av_r <= 1'b0;
            frame_prom_r <= 1'b0;
            frame_bcast_r <= 1'b0;
            frame_match_r <= '0;
        end else if (rx_clk_en) begin
            tail_prev_r <= tail_valid;
            frame_acc_r <= frame_acc_nxt;
            frame_av_r <= frame_av_nxt;
            frame_match_r <= frame_match_nxt;
            if (sof) begin
                frame_prom_r <= promisc_r;
                frame_bcast_r <= is_bcast;
            end
        end
    end

    // ************************************************************
    // Client ports
    // ************************************************************
    // No ready input: clients must take every enabled byte
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            be_rx_data <= '0;
            be_rx_data_valid <= 1'b0;
            be_rx_end_ok <= 1'b0;
            be_rx_end_error <= 1'b0;
            be_rx_filter_match <= '0;
        end else if (rx_clk_en) begin
            be_rx_data <= tail_data;
            be_rx_data_valid <= tail_valid & frame_acc_nxt;
            be_rx_filter_match <= (tail_valid & frame_acc_nxt) ? frame_match_nxt : '0;
            be_rx_end_ok <= tail_good & frame_acc_nxt & ~frame_av_nxt;
            be_rx_end_error <= frame_acc_nxt
                & (tail_bad | (tail_good & frame_av_nxt));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            media_rx_data <= '0;
            media_rx_data_valid <= 1'b0;
            media_rx_end_ok <= 1'b0;
            media_rx_end_error <= 1'b0;
            media_rx_filter_match <= '0;
        end else if (rx_clk_en) begin
            media_rx_data <= tail_data;
            media_rx_data_valid <= tail_valid;
            media_rx_filter_match <= tail_valid ? frame_match_nxt : '0;
            media_rx_end_ok <= tail_good & frame_av_nxt;
            media_rx_end_error <= tail_bad | (tail_good & ~frame_av_nxt);
        end
    end

    // Count of good best-effort frames, wraps silently
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            good_cnt_r <= '0;
        end else if (rx_clk_en && tail_good && frame_acc_nxt && !frame_av_nxt) begin
            good_cnt_r <= good_cnt_r + 16'h0001;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk iff rx_clk_en);
    endclocking
    default disable iff (reset);

    sequence s_bus_wait;
        bus_req && avs_waitrequest;
    endsequence

    sequence s_bus_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    chk_bus_answer_once: assert property (s_bus_wait |=> s_bus_answer)
        else $error("bus answer not a single low waitrequest cycle");

    chk_be_ok_route: assert property (
        be_rx_end_ok |-> !frame_av_r && frame_acc_r && !be_rx_end_error)
        else $error("best-effort end ok on an unrouted frame");

    chk_av_ok_route: assert property (
        media_rx_end_ok |-> frame_av_r && !media_rx_end_error)
        else $error("media end ok on a frame not routed there");

    chk_be_quiet_reject: assert property (
        !frame_acc_r |-> !be_rx_data_valid && !be_rx_end_ok && !be_rx_end_error)
        else $error("rejected frame visible on best-effort port");

    chk_match_all_promisc: assert property (
        be_rx_data_valid && frame_prom_r |-> be_rx_filter_match == '1)
        else $error("promiscuous frame lacks full match vector");

    chk_match_all_bcast: assert property (
        be_rx_data_valid && frame_bcast_r |-> be_rx_filter_match == '1)
        else $error("broadcast frame lacks full match vector");

    chk_match_idle_zero: assert property (
        !be_rx_data_valid |-> be_rx_filter_match == '0)
        else $error("match vector not aligned with data valid");

    chk_be_accept_cause: assert property (
        be_rx_data_valid |-> frame_prom_r || frame_bcast_r || (|be_rx_filter_match))
        else $error("best-effort data without a filter match");

    chk_media_mirror: assert property (
        be_rx_data_valid |-> media_rx_data_valid && media_rx_data == be_rx_data)
        else $error("media port does not mirror best-effort data");

    chk_hdr_delay: assert property (
        mac_rx_data_valid && !in_frame_r |-> ##17 (media_rx_data_valid
            && media_rx_data == $past(mac_rx_data, 17)))
        else $error("first byte not delayed by the header window");

endmodule : rhf_rx_filter

// [rhf_pkg.sv]
// Shared constants and helpers for the receive header filter block
package rhf_pkg;

    // ************************************************************
    // Frame header geometry
    // ************************************************************
    localparam int NUM_FILT = 8;
    localparam int HDR_BYTES = 16;
    localparam int HDR_BITS = 128;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 32;
    localparam int DA_BITS = 48;
    localparam int DLY_W = BYTE_W + 3;
    localparam logic [4:0] HDR_CNT_FULL = 5'h10;
    localparam int TPID_HI_BYTE = 12;
    localparam int TPID_LO_BYTE = 13;
    localparam int TCI_BYTE = 14;
    localparam int PRIO_LSB = 5;
    localparam int PRIO_W = 3;
    localparam logic [7:0] TPID_HI = 8'h81;
    localparam logic [7:0] TPID_LO = 8'h00;

    // ************************************************************
    // Register map (word addresses)
    // ************************************************************
    localparam int ADDR_W = 7;
    localparam logic [1:0] REGION_CTL = 2'h0;
    localparam logic [1:0] REGION_PAT = 2'h1;
    localparam logic [1:0] REGION_MSK = 2'h2;
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_PRIO = 5'h01;
    localparam logic [4:0] REG_STAT = 5'h02;
    localparam int CTRL_PROMISC = 0;
    localparam int PRIO_A_LSB = 0;
    localparam int PRIO_A_EN = 3;
    localparam int PRIO_B_LSB = 4;
    localparam int PRIO_B_EN = 7;
    localparam int STAT_AV = 8;
    localparam int STAT_CNT_LSB = 16;
    localparam logic PROMISC_RST = 1'b1;
    localparam logic [7:0] PRIO_RST = 8'hab;
    localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;

    // Merge a bus write into a word under its byte enables
    function automatic logic [WORD_W-1:0] be_merge(
        input logic [WORD_W-1:0] old_w,
        input logic [WORD_W-1:0] new_w,
        input logic [3:0] be
    );
        logic [WORD_W-1:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*BYTE_W +: BYTE_W] = new_w[b*BYTE_W +: BYTE_W];
            end
        end
        return res;
    endfunction : be_merge

    // Byte of the captured header, byte 0 received first
    function automatic logic [BYTE_W-1:0] hdr_byte(
        input logic [HDR_BITS-1:0] hdr,
        input int idx
    );
        return hdr[idx*BYTE_W +: BYTE_W];
    endfunction : hdr_byte

endpackage : rhf_pkg

// [rhf_delay.sv]
// Fixed-depth delay line for the receive byte stream
module rhf_delay
    import rhf_pkg::*;
#(
    parameter int WIDTH = DLY_W,
    parameter int DEPTH = HDR_BYTES
) (
    // Clocking
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic rx_clk_en,
    // Stream
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage_r [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_r[i] <= '0;
            end
        end else if (rx_clk_en) begin
            stage_r[0] <= din;
            for (int i = 1; i < DEPTH; i++) begin
                stage_r[i] <= stage_r[i-1];
            end
        end
    end

    assign dout = stage_r[DEPTH-1];

endmodule : rhf_delay

// [rhf_filter_bank.sv]
// Eight pattern and mask comparators over the captured header
module rhf_filter_bank
    import rhf_pkg::*;
(
    // Header and configuration
    input wire logic [HDR_BITS-1:0] hdr,
    input wire logic [NUM_FILT-1:0][HDR_BITS-1:0] pattern,
    input wire logic [NUM_FILT-1:0][HDR_BITS-1:0] enable_mask,
    // Result
    output logic [NUM_FILT-1:0] hit
);

    // Masked-off bits are don't care; all enabled bits must agree
    always_comb begin
        for (int f = 0; f < NUM_FILT; f++) begin
            hit[f] = ~|((hdr ^ pattern[f]) & enable_mask[f]);
        end
    end

endmodule : rhf_filter_bank

// [rhf_client_model.sv]
// Behavioural model of a receive client that keeps good frames and drops errored ones
module rhf_client_model
    import rhf_pkg::*;
(
    // Clocking
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic rx_clk_en,
    // Client port
    input wire logic [BYTE_W-1:0] rx_data,
    input wire logic rx_data_valid,
    input wire logic rx_end_ok,
    input wire logic rx_end_error,
    // Results
    output int ok_cnt,
    output int drop_cnt,
    output int last_len,
    output logic [BYTE_W-1:0] last_first
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [BYTE_W-1:0] buf_q[$];

    // No ready signal: every enabled byte must be taken
    always @(posedge sys_clk) begin
        if (reset) begin
            ok_cnt <= 0;
            drop_cnt <= 0;
            last_len <= 0;
            last_first <= 8'h00;
            buf_q.delete();
        end else if (rx_clk_en) begin
            if (rx_data_valid) begin
                buf_q.push_back(rx_data);
            end
            if (rx_end_ok) begin
                ok_cnt <= ok_cnt + 1;
                last_len <= buf_q.size();
                last_first <= buf_q[0];
                buf_q.delete();
            end else if (rx_end_error) begin
                drop_cnt <= drop_cnt + 1;
                buf_q.delete();
            end
        end
    end
endmodule : rhf_client_model

// [rhf_rx_filter_test.sv]
// Self-checking testbench for the receive header filter
module rhf_rx_filter_test;
    import rhf_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int FLEN = 20;
    logic sys_clk = 0, reset = 1, rx_clk_en = 1;
    logic [ADDR_W-1:0] avs_address = 7'h00;
    logic avs_read = 0, avs_write = 0;
    logic [WORD_W-1:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
    logic [3:0] avs_byteenable = 4'hf;
    logic avs_waitrequest;
    logic [BYTE_W-1:0] mac_rx_data = 8'h00, be_rx_data, media_rx_data, be_first, md_first;
    logic mac_rx_data_valid = 0, mac_rx_good_frame = 0, mac_rx_bad_frame = 0;
    logic be_rx_data_valid, be_rx_end_ok, be_rx_end_error;
    logic media_rx_data_valid, media_rx_end_ok, media_rx_end_error;
    logic [NUM_FILT-1:0] be_rx_filter_match, media_rx_filter_match, be_mv, md_mv;
    logic be_prev = 0;
    int be_bytes = 0, holes = 0;
    int be_ok, be_drop, be_len, md_ok, md_drop, md_len;
    int bad_count = 0, cmp_count = 0;

    always #12.5 sys_clk = ~sys_clk;

    rhf_rx_filter rhf_rx_filter_i (.*);
    rhf_client_model be_client (.sys_clk, .reset, .rx_clk_en, .rx_data(be_rx_data),
        .rx_data_valid(be_rx_data_valid), .rx_end_ok(be_rx_end_ok),
        .rx_end_error(be_rx_end_error), .ok_cnt(be_ok), .drop_cnt(be_drop),
        .last_len(be_len), .last_first(be_first));
    rhf_client_model media_client (.sys_clk, .reset, .rx_clk_en, .rx_data(media_rx_data),
        .rx_data_valid(media_rx_data_valid), .rx_end_ok(media_rx_end_ok),
        .rx_end_error(media_rx_end_error), .ok_cnt(md_ok), .drop_cnt(md_drop),
        .last_len(md_len), .last_first(md_first));

    // Port monitor: best-effort presence and holes in a frame, match vector of each port
    always @(posedge sys_clk) begin
        if (rx_clk_en) begin
            if (be_rx_data_valid) begin
                be_bytes <= be_bytes + 1;
                be_mv <= be_rx_filter_match;
            end
            if (media_rx_data_valid) begin
                md_mv <= media_rx_filter_match;
            end
            if (be_prev && !be_rx_data_valid && !be_rx_end_ok && !be_rx_end_error) begin
                holes <= holes + 1;
            end
            be_prev <= be_rx_data_valid;
        end
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
        int n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
        check("bus answer cycles", n, 2);
    endtask : bus

    function automatic logic [127:0] mk(input logic [47:0] da, input logic [23:0] tag,
                                        input logic [7:0] b15);
        return {b15, tag[7:0], tag[15:8], tag[23:16], 48'h0000_0a0b_0c0d, da};
    endfunction : mk

    // Outcome codes: 0 nothing, 1 end ok, 2 end error
    task automatic frame(input logic [127:0] hdr, input logic good, input logic slow,
                         input int be_x, input int md_x, input logic [7:0] mv);
        int bo = be_ok, bd = be_drop, mo = md_ok, mdd = md_drop;
        int bb = be_bytes, hh = holes;
        for (int k = 0; k < FLEN; k++) begin
            mac_rx_data <= (k < HDR_BYTES) ? hdr[8*k +: 8] : 8'(k * 3);
            mac_rx_data_valid <= 1'b1;
            @(posedge sys_clk);
            if (slow) begin
                rx_clk_en <= 1'b0;
                @(posedge sys_clk);
                rx_clk_en <= 1'b1;
            end
        end
        mac_rx_data_valid <= 1'b0;
        mac_rx_good_frame <= good;
        mac_rx_bad_frame <= !good;
        @(posedge sys_clk);
        mac_rx_good_frame <= 1'b0;
        mac_rx_bad_frame <= 1'b0;
        repeat (30) @(posedge sys_clk);
        check("be byte count", be_bytes - bb, (be_x != 0) ? FLEN : 0);
        check("be ok count", be_ok - bo, be_x == 1);
        check("be error count", be_drop - bd, be_x == 2);
        check("media ok count", md_ok - mo, md_x == 1);
        check("media error count", md_drop - mdd, md_x == 2);
        check("be holes", holes - hh, 0);
        check("media match vector", md_mv, mv);
        if (be_x != 0) check("be match vector", be_mv, mv);
        if (be_x == 1) check("be length", be_len, FLEN);
        if (be_x == 1) check("be first byte", be_first, hdr[7:0]);
        if (md_x == 1) check("media length", md_len, FLEN);
        if (md_x == 1) check("media first byte", md_first, hdr[7:0]);
    endtask : frame

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        repeat (8) @(posedge sys_clk);
        check("waitrequest in reset", avs_waitrequest, 1);
        check("be valid in reset", be_rx_data_valid, 0);
        reset <= 1'b0;
        @(posedge sys_clk);
        bus(0, 7'h00, 0);
        check("ctrl reset", rd, 32'h0000_0001);
        bus(0, 7'h01, 0);
        check("prio reset", rd, 32'h0000_00ab);
        bus(1, 7'h60, 32'h1234_5678);
        bus(0, 7'h60, 0);
        check("unmapped read", rd, 0);
        // Promiscuous, stalled enable, unknown destination
        frame(mk(48'h0000_5e00_0102, 24'h0800_00, 8'h00), 1, 1, 1, 2, 8'hff);
        bus(1, 7'h00, 0);
        bus(0, 7'h00, 0);
        check("ctrl write", rd, 0);
        // Filter 3: full address; word 1 upper half is don't care
        bus(1, 7'h2c, 32'h5e00_0102);
        bus(1, 7'h2d, 32'hdead_0000);
        bus(1, 7'h4c, 32'hffff_ffff);
        bus(1, 7'h4d, 32'h0000_ffff);
        // Filter 7: last header bit only
        bus(1, 7'h3f, 32'h8000_0000);
        bus(1, 7'h5f, 32'h8000_0000);
        // An all-zero mask matches anything; park the rest on header bit 48
        for (int f = 0; f < NUM_FILT; f++) begin
            if (f != 3 && f != 7) bus(1, 7'h41 + 7'(4 * f), 32'h0001_0000);
        end
        bus(0, 7'h4d, 0);
        check("mask readback", rd, 32'h0000_ffff);
        frame(mk(48'h0000_5e00_0102, 24'h0800_00, 8'h00), 1, 0, 1, 2, 8'h08);
        frame(mk(48'h0000_5e00_0103, 24'h0800_00, 8'h00), 1, 0, 0, 2, 8'h00);
        frame(mk(48'h0000_5e00_0103, 24'h0800_00, 8'h80), 1, 0, 1, 2, 8'h80);
        frame(mk(48'h0000_5e00_0102, 24'h0800_00, 8'h80), 0, 0, 2, 2, 8'h88);
        frame(mk(48'hffff_ffff_ffff, 24'h0800_00, 8'h00), 1, 1, 1, 2, 8'hff);
        frame(mk(48'h0000_5e00_0102, 24'h8100_60, 8'h00), 1, 0, 2, 1, 8'h08);
        frame(mk(48'h0000_5e00_0102, 24'h8100_40, 8'h00), 0, 0, 2, 2, 8'h08);
        frame(mk(48'h0000_5e00_0103, 24'h8100_40, 8'h00), 1, 0, 0, 1, 8'h00);
        // Promiscuous again: a frame no filter matches still gets through
        bus(1, 7'h00, 1);
        frame(mk(48'h0000_5e00_0103, 24'h0800_00, 8'h00), 1, 0, 1, 2, 8'hff);
        bus(0, 7'h02, 0);
        check("status word", rd, 32'h0005_00ff);
        close_out();
    end

    // Whole run is about 620 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        close_out();
    end
endmodule : rhf_rx_filter_test
